// file: bench/crt_rtc_properties.sv
// Concurrent checks on the calendar clock register port
`timescale 1ns/10ps
`default_nettype none
module crt_rtc_checker
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic irq,
   input wire logic second_pulse
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_rd_idle;
      reg_rdata != 8'h00 |-> $past(reg_rd);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
   property p_pulse_one;
      second_pulse |=> !second_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("second pulse too long");
   property p_wren_zero;
      reg_rd && reg_addr == 16'h201f |=> reg_rdata == 8'h00;
   endproperty
   a_wren_zero: assert property (p_wren_zero) else $error("unlock byte readable");
   property p_cap_width;
      reg_rd && reg_addr == 16'h2011 |=> !reg_rdata[7];
   endproperty
   a_cap_width: assert property (p_cap_width) else $error("cap trim too wide");
   property p_trim_high;
      reg_rd && reg_addr == 16'h201c |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_trim_high: assert property (p_trim_high) else $error("coarse top too wide");
   property p_sec_range;
      reg_rd && reg_addr == 16'h2015 |=> reg_rdata <= 8'h3b;
   endproperty
   a_sec_range: assert property (p_sec_range) else $error("seconds out of range");
   property p_hour_range;
      reg_rd && reg_addr == 16'h2017 |=> reg_rdata <= 8'h17;
   endproperty
   a_hour_range: assert property (p_hour_range) else $error("hours out of range");
   property p_wday_range;
      reg_rd && reg_addr == 16'h2018 |=> reg_rdata inside {[8'h01:8'h07]};
   endproperty
   a_wday_range: assert property (p_wday_range) else $error("weekday out of range");
   property p_month_range;
      reg_rd && reg_addr == 16'h201a |=> reg_rdata inside {[8'h01:8'h0c]};
   endproperty
   a_month_range: assert property (p_month_range) else $error("month out of range");
   property p_restart;
      reg_wr && reg_addr == 16'h2010 && reg_wdata[0] ##1 reg_rd && reg_addr == 16'h2014 |=> reg_rdata == 8'hff;
   endproperty
   a_restart: assert property (p_restart) else $error("fraction not restarted");
   c_restart: cover property (reg_wr && reg_addr == 16'h2010 && reg_wdata[0]);
   c_unlock: cover property (reg_wr && reg_addr == 16'h201f ##1 reg_wr && reg_addr == 16'h2015);
   c_sec_read: cover property (reg_rd && reg_addr == 16'h2015);
   c_second: cover property (second_pulse ##1 irq);
endmodule
bind crt_rtc crt_rtc_checker crt_rtc_checker_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .second_pulse(second_pulse));
`default_nettype wire

// file: bench/tb_calendar_rtc_with_rate_trim.sv
// Self-checking bench of the calendar clock register port
`timescale 1ns/10ps
`default_nettype none
module tb_calendar_rtc_with_rate_trim;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic irq;
   logic second_pulse;
   logic rd_pending = 1'b0;
   logic [23:0] exp_q[$];
   logic [23:0] e;
   logic [7:0] v;
   logic [7:0] sec_v;
   logic [16:0] coarse;
   int fails = 0;
   int samples_checked = 0;
   logic [15:0] taddr[7] = '{16'h2015, 16'h2016, 16'h2017, 16'h2018, 16'h2019, 16'h201a, 16'h201b};
   int lo[7] = '{0, 0, 0, 1, 1, 1, 0};
   // Dates kept to 28 so no month length matters
   int span[7] = '{60, 60, 24, 7, 28, 12, 100};
   // Large cap gain lets a full cap trim pass a second in about 8300 cycles
   localparam int CAP_FAST = 1 << 21;
   localparam int SEC_LIMIT = 10000;
   int n;
   // Last second of a day: leap February of year 00, end of year 99, plain February
   logic [7:0] t_start[3][7] = '{'{8'h3b, 8'h3b, 8'h17, 8'h07, 8'h1c, 8'h02, 8'h00},
      '{8'h3b, 8'h3b, 8'h17, 8'h03, 8'h1f, 8'h0c, 8'h63}, '{8'h3b, 8'h3b, 8'h17, 8'h05, 8'h1c, 8'h02, 8'h01}};
   logic [7:0] t_end[3][7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h1d, 8'h02, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h03, 8'h01}};
   always #4 core_clk = ~core_clk;
   crt_rtc #(.CAP_GAIN(CAP_FAST)) crt_rtc_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .second_pulse(second_pulse));
   // ****************
   // Tasks
   // ****************
   task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task stop_test;
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Strobes left high so transfers can follow back to back
   task wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd(input logic [15:0] a, input logic [7:0] x);
      exp_q.push_back({a, x});
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   // ****************
   // Read monitor
   // ****************
   always @(posedge core_clk)
   begin
      if (rd_pending)
      begin
         e = exp_q.pop_front();
         cmp($sformatf("read %h", e[23:8]), e[7:0], reg_rdata);
      end
      rd_pending <= reg_rd;
   end
   // Three simulated seconds take about 25000 cycles
   initial
   begin
      repeat (40000) @(posedge core_clk);
      fails++;
      stop_test;
   end
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      v = $urandom(32'hf67c);
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(16'h2011, 8'h40);
      rd(16'h201c, 8'h04);
      rd(16'h201d, 8'h00);
      rd(16'h201e, 8'h00);
      rd(16'h201f, 8'h00);
      rd(16'h2014, 8'hff);
      rd(16'h2013, 8'h00);
      rd(16'h2000, 8'h00);
      // Bit 6 kept so the fast cap gain cannot reach a second here
      v = 8'($urandom) | 8'h40;
      wr(16'h2011, v);
      rd(16'h2011, {1'b0, v[6:0]});
      coarse = 17'h0ffbf + 17'($urandom % 130);
      wr(16'h201c, {5'h1f, coarse[16:14]});
      wr(16'h201d, coarse[13:6]);
      wr(16'h201e, {coarse[5:0], v[1:0]});
      rd(16'h201c, {5'h00, coarse[16:14]});
      rd(16'h201d, coarse[13:6]);
      rd(16'h201e, {coarse[5:0], v[1:0]});
      for (int i = 0; i < 7; i++)
      begin
         v = 8'(lo[i] + $urandom % span[i]);
         wr(16'h201f, 8'($urandom));
         wr(taddr[i], v);
         rd(taddr[i], v);
      end
      sec_v = 8'($urandom % 60);
      wr(16'h201f, 8'h00);
      wr(16'h2015, sec_v);
      wr(16'h2015, sec_v ^ 8'h01);
      rd(16'h2015, sec_v);
      wr(16'h201f, 8'h00);
      wr(16'h2011, 8'h40);
      wr(16'h2015, sec_v ^ 8'h01);
      rd(16'h2015, sec_v);
      wr(16'h201f, 8'h00);
      rd(16'h2011, 8'h40);
      sec_v = sec_v ^ 8'h01;
      wr(16'h2015, sec_v);
      rd(16'h2015, sec_v);
      wr(16'h2010, 8'h01);
      rd(16'h2014, 8'hff);
      wr(16'h2013, 8'h07);
      rd(16'h2013, 8'h07);
      wr(16'h2012, 8'h07);
      rd(16'h2012, 8'h00);
      idle;
      cmp("irq", 8'h00, {7'h00, irq});
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(16'h2015, sec_v);
      rd(16'h201c, 8'h04);
      rd(16'h2013, 8'h00);
      wr(16'h2013, 8'h07);
      wr(16'h2011, 8'h7f);
      for (int c = 0; c < 3; c++)
      begin
         wr(16'h2010, 8'h01);
         wr(16'h2012, 8'h07);
         for (int i = 0; i < 7; i++)
         begin
            wr(16'h201f, 8'($urandom));
            wr(taddr[i], t_start[c][i]);
         end
         idle;
         n = 0;
         while (second_pulse !== 1'b1 && n < SEC_LIMIT)
         begin
            @(posedge core_clk);
            n++;
         end
         cmp("second pulse", 8'h01, {7'h00, second_pulse});
         cmp("irq", 8'h01, {7'h00, irq});
         rd(16'h2012, 8'h07);
         for (int i = 0; i < 7; i++)
            rd(taddr[i], t_end[c][i]);
      end
      idle;
      idle;
      stop_test;
   end
endmodule
`default_nettype wire

// file: src/crt_calendar_step.v
// Calendar carry logic: one second added to a time and date
`timescale 1ns/10ps
`default_nettype none
module crt_calendar_step
(
   input wire [5:0] sec_in,
   input wire [5:0] min_in,
   input wire [4:0] hour_in,
   input wire [2:0] wday_in,
   input wire [4:0] mday_in,
   input wire [3:0] mon_in,
   input wire [7:0] year_in,
   output reg [5:0] sec_out,
   output reg [5:0] min_out,
   output reg [4:0] hour_out,
   output reg [2:0] wday_out,
   output reg [4:0] mday_out,
   output reg [3:0] mon_out,
   output reg [7:0] year_out,
   output reg min_carry,
   output reg day_carry
);

   // ****************************************
   // Month length
   // ****************************************
   function [4:0] crt_month_len;
      input [3:0] mon;
      input [7:0] year;
      begin
         case (mon)
            4'h2: crt_month_len = (year[1:0] == 2'h0) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hb: crt_month_len = 5'd30;
            default: crt_month_len = 5'd31;
         endcase
      end
   endfunction

   always @*
   begin
      sec_out = sec_in;
      min_out = min_in;
      hour_out = hour_in;
      wday_out = wday_in;
      mday_out = mday_in;
      mon_out = mon_in;
      year_out = year_in;
      min_carry = 1'b0;
      day_carry = 1'b0;
      if (sec_in < 6'd59)
         sec_out = sec_in + 6'd1;
      else
      begin
         sec_out = 6'd0;
         min_carry = 1'b1;
         if (min_in < 6'd59)
            min_out = min_in + 6'd1;
         else
         begin
            min_out = 6'd0;
            if (hour_in < 5'd23)
               hour_out = hour_in + 5'd1;
            else
            begin
               hour_out = 5'd0;
               day_carry = 1'b1;
               wday_out = (wday_in >= 3'd7) ? 3'd1 : wday_in + 3'd1;
               if (mday_in < crt_month_len(mon_in, year_in))
                  mday_out = mday_in + 5'd1;
               else
               begin
                  mday_out = 5'd1;
                  if (mon_in < 4'd12)
                     mon_out = mon_in + 4'd1;
                  else
                  begin
                     mon_out = 4'd1;
                     year_out = (year_in >= 8'd99) ? 8'd0 : year_in + 8'd1;
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: src/crt_defines.vh
// Register map, reset values and timing counts of the calendar clock
`ifndef CRT_DEFINES_VH
`define CRT_DEFINES_VH
`define CRT_OFF_RESTART 16'h2010
`define CRT_OFF_CAP_TRIM 16'h2011
`define CRT_OFF_FRACTION 16'h2014
`define CRT_OFF_SECONDS 16'h2015
`define CRT_OFF_MINUTES 16'h2016
`define CRT_OFF_HOURS 16'h2017
`define CRT_OFF_WEEKDAY 16'h2018
`define CRT_OFF_MONTH_DAY 16'h2019
`define CRT_OFF_MONTH 16'h201a
`define CRT_OFF_YEAR 16'h201b
`define CRT_OFF_TRIM_HIGH 16'h201c
`define CRT_OFF_TRIM_MID 16'h201d
`define CRT_OFF_TRIM_LOW 16'h201e
`define CRT_OFF_WRITE_EN 16'h201f
`define CRT_OFF_IRQ_STATUS 16'h2012
`define CRT_OFF_IRQ_MASK 16'h2013
`define CRT_RST_CAP_TRIM 7'h40
`define CRT_RST_TRIM_HIGH 3'h4
`define CRT_RST_TRIM_MID 8'h00
`define CRT_RST_TRIM_LOW 8'h00
`define CRT_TRIM_UNITY 19'h40000
`define CRT_CORE_HZ 125000000
`define CRT_RTC_HZ 32768
`define CRT_IRQ_SECOND 0
`define CRT_IRQ_MINUTE 1
`define CRT_IRQ_DAY 2
`endif

// file: src/crt_rtc.v
// Calendar real-time clock with fraction countdown and rate trims
// How it works
// - Coarse trim 17 bits, top three reset to 4, spread over three bytes.
// - Writing one to the restart bit restarts the fraction counter.
// - Seven-bit analog cap trim, reset 40, steers the clock rate.
// - Seven time bytes: widths 6, 6, 5, 3, 5, 4, 8.
// - An accepted time write loads the running clock.
// - Seconds and minutes 0 to 59, hours 0 to 23.
// - Weekday 1 to 7 with 1 Sunday, date 1 to 31.
// - Year 0 to 99, years divisible by four are leap.
// - Time keeps counting; supply modes are not handled here, backup supply taken as always good.
// - Device reset leaves the time registers untouched.
// - Read-only fraction countdown in 1/256 steps to next second.
// - Write-enable location is write-only, eight bits, needed before each time write.
`timescale 1ns/10ps
`default_nettype none
`include "crt_defines.vh"
module crt_rtc
#(
   parameter ACC_W = 19,
   parameter CAP_GAIN = 8
)
(
   input wire core_clk,
   input wire rst,
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output wire irq,
   output reg second_pulse
);

   // ****************************************
   // Rate generation
   // ****************************************
   // Phase accumulator stands in for the 32768 Hz crystal; one wrap is one
   // 1/256 tick of the RTC cycle. Step is scaled by the rate trims.
   localparam [63:0] BASE_STEP_WIDE =
      ((`CRT_RTC_HZ / 128) * 64'd4294967296 / `CRT_CORE_HZ);
   localparam [ACC_W+12:0] BASE_STEP = BASE_STEP_WIDE[ACC_W+12:0];
   // Trim product needs headroom: 32-bit step times 19-bit trim
   localparam [63:0] TRIM_UNITY_WIDE = {45'h0, `CRT_TRIM_UNITY};

   reg [2:0] trim_high_reg;
   reg [7:0] trim_mid_reg;
   reg [7:0] trim_low_reg;
   reg [6:0] cap_trim_reg;
   reg [7:0] fraction_reg;
   reg [31:0] phase_reg;
   reg unlock_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_mask_reg;

   reg [5:0] sec_reg;
   reg [5:0] min_reg;
   reg [4:0] hour_reg;
   reg [2:0] wday_reg;
   reg [4:0] mday_reg;
   reg [3:0] mon_reg;
   reg [7:0] year_reg;

   wire [16:0] coarse_trim;
   wire [1:0] fine_trim;
   wire [18:0] combined_trim;
   wire [8:0] cap_offset;
   wire [63:0] cap_offset_wide;
   wire [63:0] trim_product;
   wire [63:0] step_base;
   wire [63:0] cap_adjust;
   wire [63:0] step_wide;
   wire [31:0] step_val;
   wire [32:0] phase_sum;
   wire tick;
   wire second_event;

   assign coarse_trim = {trim_high_reg, trim_mid_reg, trim_low_reg[7:2]};
   assign fine_trim = trim_low_reg[1:0];
   assign combined_trim = {coarse_trim, fine_trim};
   // Coarse and fine trim scale the nominal step; unity leaves it alone
   assign trim_product = {{(64-(ACC_W+13)){1'b0}}, BASE_STEP} * {45'h0, combined_trim};
   assign step_base = trim_product / TRIM_UNITY_WIDE;
   // cap trim around center
   // Offset kept in two's complement and widened by hand: an unsigned sum
   // would otherwise turn a slow-down into a speed-up.
   assign cap_offset = {2'b00, cap_trim_reg} - 9'h040;
   assign cap_offset_wide = {{55{cap_offset[8]}}, cap_offset};
   assign cap_adjust = cap_offset_wide * CAP_GAIN;
   assign step_wide = step_base + cap_adjust;
   assign step_val = step_wide[31:0];
   assign phase_sum = {1'b0, phase_reg} + {1'b0, step_val};
   assign tick = phase_sum[32];
   assign second_event = tick && (fraction_reg == 8'h00);

   // ****************************************
   // Register decode
   // ****************************************
   function crt_is_time;
      input [15:0] addr;
      begin
         crt_is_time = (addr >= `CRT_OFF_SECONDS) && (addr <= `CRT_OFF_YEAR);
      end
   endfunction

   wire wr_time;
   wire wr_restart;
   assign wr_time = reg_wr && crt_is_time(reg_addr) && unlock_reg;
   assign wr_restart = reg_wr && (reg_addr == `CRT_OFF_RESTART) && reg_wdata[0];

   // A restart landing on a boundary wins: that second is dropped whole,
   // so status flags and the pulse agree with the time except when a same-cycle time write drops the advance.
   wire second_take;
   assign second_take = second_event && !wr_restart;
   // Time write beats a same-cycle advance; that advance is lost
   wire time_advance;
   assign time_advance = second_take && !wr_time;

   wire wr_sec;
   wire wr_min;
   wire wr_hour;
   wire wr_wday;
   wire wr_mday;
   wire wr_mon;
   wire wr_year;
   assign wr_sec = wr_time && (reg_addr == `CRT_OFF_SECONDS);
   assign wr_min = wr_time && (reg_addr == `CRT_OFF_MINUTES);
   assign wr_hour = wr_time && (reg_addr == `CRT_OFF_HOURS);
   assign wr_wday = wr_time && (reg_addr == `CRT_OFF_WEEKDAY);
   assign wr_mday = wr_time && (reg_addr == `CRT_OFF_MONTH_DAY);
   assign wr_mon = wr_time && (reg_addr == `CRT_OFF_MONTH);
   assign wr_year = wr_time && (reg_addr == `CRT_OFF_YEAR);

   // ****************************************
   // Calendar
   // ****************************************
   wire [5:0] sec_n;
   wire [5:0] min_n;
   wire [4:0] hour_n;
   wire [2:0] wday_n;
   wire [4:0] mday_n;
   wire [3:0] mon_n;
   wire [7:0] year_n;
   wire min_carry;
   wire day_carry;

   crt_calendar_step u_step
   (
      .sec_in(sec_reg),
      .min_in(min_reg),
      .hour_in(hour_reg),
      .wday_in(wday_reg),
      .mday_in(mday_reg),
      .mon_in(mon_reg),
      .year_in(year_reg),
      .sec_out(sec_n),
      .min_out(min_n),
      .hour_out(hour_n),
      .wday_out(wday_n),
      .mday_out(mday_n),
      .mon_out(mon_n),
      .year_out(year_n),
      .min_carry(min_carry),
      .day_carry(day_carry)
   );

   // time kept across reset
   // Time has no reset on purpose: a core reset must not disturb it.
   // Backup supply taken as always good; power modes live outside.
   // load wins, each field at its width
   always @(posedge core_clk)
   begin
      if (wr_sec)
         sec_reg <= reg_wdata[5:0];
      else if (time_advance)
         sec_reg <= sec_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_min)
         min_reg <= reg_wdata[5:0];
      else if (time_advance)
         min_reg <= min_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_hour)
         hour_reg <= reg_wdata[4:0];
      else if (time_advance)
         hour_reg <= hour_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_wday)
         wday_reg <= reg_wdata[2:0];
      else if (time_advance)
         wday_reg <= wday_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_mday)
         mday_reg <= reg_wdata[4:0];
      else if (time_advance)
         mday_reg <= mday_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_mon)
         mon_reg <= reg_wdata[3:0];
      else if (time_advance)
         mon_reg <= mon_n;
   end

   always @(posedge core_clk)
   begin
      if (wr_year)
         year_reg <= reg_wdata;
      else if (time_advance)
         year_reg <= year_n;
   end

   // ****************************************
   // Control registers and fraction counter
   // ****************************************
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         trim_high_reg <= `CRT_RST_TRIM_HIGH;
         trim_mid_reg <= `CRT_RST_TRIM_MID;
         trim_low_reg <= `CRT_RST_TRIM_LOW;
         cap_trim_reg <= `CRT_RST_CAP_TRIM;
         fraction_reg <= 8'hff;
         phase_reg <= 32'h00000000;
         unlock_reg <= 1'b0;
         irq_mask_reg <= 3'h0;
         second_pulse <= 1'b0;
      end
      else
      begin
         second_pulse <= second_take;
         if (wr_restart)
         begin
            fraction_reg <= 8'hff;
            phase_reg <= 32'h00000000;
         end
         else
         begin
            phase_reg <= phase_sum[31:0];
            if (tick)
               fraction_reg <= fraction_reg - 8'h01;
         end
         if (reg_wr)
            unlock_reg <= (reg_addr == `CRT_OFF_WRITE_EN);
         if (reg_wr)
         begin
            case (reg_addr)
               `CRT_OFF_CAP_TRIM: cap_trim_reg <= reg_wdata[6:0];
               `CRT_OFF_TRIM_HIGH: trim_high_reg <= reg_wdata[2:0];
               `CRT_OFF_TRIM_MID: trim_mid_reg <= reg_wdata;
               `CRT_OFF_TRIM_LOW: trim_low_reg <= reg_wdata;
               `CRT_OFF_IRQ_MASK: irq_mask_reg <= reg_wdata[2:0];
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   wire [2:0] irq_events;
   wire [2:0] irq_clear;
   assign irq_events = {second_take && day_carry, second_take && min_carry, second_take};
   assign irq_clear = (reg_wr && reg_addr == `CRT_OFF_IRQ_STATUS) ? reg_wdata[2:0] : 3'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_irq
         // Set beats a simultaneous clear so no event is lost
         always @(posedge core_clk or posedge rst)
         begin
            if (rst)
               irq_status_reg[gi] <= 1'b0;
            else if (irq_events[gi])
               irq_status_reg[gi] <= 1'b1;
            else if (irq_clear[gi])
               irq_status_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   assign irq = |(irq_status_reg & irq_mask_reg);

   // ****************************************
   // Read port
   // ****************************************
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `CRT_OFF_RESTART: reg_rdata <= 8'h00;
            `CRT_OFF_CAP_TRIM: reg_rdata <= {1'b0, cap_trim_reg};
            `CRT_OFF_IRQ_STATUS: reg_rdata <= {5'h00, irq_status_reg};
            `CRT_OFF_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_reg};
            `CRT_OFF_FRACTION: reg_rdata <= fraction_reg;
            `CRT_OFF_SECONDS: reg_rdata <= {2'b00, sec_reg};
            `CRT_OFF_MINUTES: reg_rdata <= {2'b00, min_reg};
            `CRT_OFF_HOURS: reg_rdata <= {3'b000, hour_reg};
            `CRT_OFF_WEEKDAY: reg_rdata <= {5'h00, wday_reg};
            `CRT_OFF_MONTH_DAY: reg_rdata <= {3'b000, mday_reg};
            `CRT_OFF_MONTH: reg_rdata <= {4'h0, mon_reg};
            `CRT_OFF_YEAR: reg_rdata <= year_reg;
            `CRT_OFF_TRIM_HIGH: reg_rdata <= {5'h00, trim_high_reg};
            `CRT_OFF_TRIM_MID: reg_rdata <= trim_mid_reg;
            `CRT_OFF_TRIM_LOW: reg_rdata <= trim_low_reg;
            // Write-enable location and unmapped addresses read zero
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end
endmodule
`default_nettype wire
